// ==== hdl/supply_shutdown_depop_regs.vh ====
/*
 * Register offsets, field positions, reset values and timing constants
 * of the supply, shutdown and de-pop register group.
 * Assumes a 200 MHz clock and 32-bit APB with byte addresses.
 */
`ifndef SUPPLY_SHUTDOWN_DEPOP_REGS_VH
`define SUPPLY_SHUTDOWN_DEPOP_REGS_VH

// Printed register indexes; byte address is four times the index
`define IDX_SUPPLY_STATUS 8'h03
`define IDX_BUS_ADDR_CFG 8'h04
`define IDX_CHARGE_SHUTDOWN_BEHAVIOUR_SELECT 8'h05
`define IDX_HP_DEPOP_CFG 8'h06
`define IDX_IRQ_STATUS 8'h08
`define IDX_IRQ_MASK 8'h09
`define IDX_OUT_STATUS 8'h0A

// Reset values
`define RST_SUPPLY_STATUS 8'h00
`define RST_BUS_ADDR_CFG 8'h00
`define RST_CHARGE_SHUTDOWN_BEHAVIOUR_SELECT 8'h15
`define RST_HP_DEPOP_CFG 8'h55

// Field positions
`define BIT_ANALOG_FLAG 7
`define BIT_IO_FLAG 6
`define BIT_BROWNOUT_FLAG 1
`define BIT_SLEEP_EXIT 0
`define BIT_BROADCAST_EN 1
`define WRMASK_SUPPLY_STATUS 8'h01
`define WRMASK_BUS_ADDR_CFG 8'hFF

// Shutdown behaviour codes
`define SHDN_IMMEDIATE 2'h0
`define SHDN_TIMEOUT 2'h1
`define SHDN_CLEAN 2'h2

// Timing: clock in MHz, times in microseconds
`define CLK_MHZ 200
`define QCHG_T0_US 2500
`define QCHG_T1_US 12500
`define QCHG_T2_US 25000
`define QCHG_T3_US 50000
`define KA_T0_US 30000
`define KA_T1_US 25000
`define KA_T2_US 10000
`define KA_T3_US 5000

`endif

// ==== hdl/supply_shutdown_depop_regs.v ====
/*
 * Supply status, brownout, broadcast addressing, quick-charge timing,
 * core regulator shutdown timing and headphone de-pop configuration,
 * reached over APB with an interrupt on status events.
 * Assumes supply comparators, brownout and clean-shutdown indications
 * arrive asynchronously from the analog domain.
 */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "supply_shutdown_depop_regs.vh"

// Notes on behaviour
// - The analog supply flag is set above 2 V and then forces the analog supply mode to 0.
// - The I/O supply flag is set above 2 V and then forces the I/O supply mode to 0.
// - A brownout shutdown is reported as a 1 in status bit 1, otherwise 0.
// - Writable status bit 0 picks staying in sleep (0) or leaving sleep (1) after brownout.
// - The broadcast enable bit makes the device answer at a fixed address with low pin bits zero.
// - The two-bit quick-charge field selects 2.5, 12.5, 25 or 50 ms.
// - Shutdown code 0 turns the core regulator off as soon as the I/O supply goes.
// - Shutdown code 1 keeps the regulator on for the keep-alive time, then forces it off.
// - Shutdown code 2 keeps the regulator on until clean shutdown; code 3 must not be used.
// - The keep-alive field selects 30, 25, 10 or 5 ms.
// - The series-resistor field selects the de-pop resistor; codes above 8 must not be used.
// - The cap charging-time field selects 2 ms to 5 s for codes 0 to 9; 10 to 15 are reserved.
module supply_shutdown_depop_regs #(
   parameter QCHG_T0_CYC = `QCHG_T0_US * `CLK_MHZ,
   parameter QCHG_T1_CYC = `QCHG_T1_US * `CLK_MHZ,
   parameter QCHG_T2_CYC = `QCHG_T2_US * `CLK_MHZ,
   parameter QCHG_T3_CYC = `QCHG_T3_US * `CLK_MHZ,
   parameter KA_T0_CYC = `KA_T0_US * `CLK_MHZ,
   parameter KA_T1_CYC = `KA_T1_US * `CLK_MHZ,
   parameter KA_T2_CYC = `KA_T2_US * `CLK_MHZ,
   parameter KA_T3_CYC = `KA_T3_US * `CLK_MHZ,
   parameter [6:0] BROADCAST_BASE = 7'h50,
   parameter CNT_W = 24
) (
   // Clock and reset
   input wire clk_i,
   input wire rstn_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Analog indications, asynchronous
   input wire analog_supply_high_i,
   input wire io_supply_high_i,
   input wire io_supply_present_i,
   input wire brownout_event_i,
   input wire clean_shutdown_done_i,
   input wire quick_charge_start_i,
   // Pin-selected address bits and configured modes
   input wire [1:0] addr_pins_i,
   input wire analog_supply_mode_setting_i,
   input wire io_supply_mode_setting_i,
   // Effective controls
   output reg analog_supply_mode_o,
   output reg io_supply_mode_o,
   output reg [6:0] bus_target_addr_o,
   output reg quick_charge_active_o,
   output reg digital_core_regulator_on_o,
   output reg sleep_exit_o,
   output reg [3:0] headphone_series_resistor_select_o,
   output reg [3:0] headphone_cap_charge_time_o,
   // Interrupt
   output reg irq_o
);

   // Synchronisers for asynchronous inputs
   localparam NSYNC = 6;
   wire [NSYNC-1:0] async_in;
   reg [NSYNC-1:0] sync1_reg;
   reg [NSYNC-1:0] sync2_reg;
   assign async_in = {quick_charge_start_i, clean_shutdown_done_i, brownout_event_i,
                      io_supply_present_i, io_supply_high_i, analog_supply_high_i};
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
      end else begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
      end
   end
   wire analog_high = sync2_reg[0];
   wire io_high = sync2_reg[1];
   wire io_present = sync2_reg[2];
   wire brownout = sync2_reg[3];
   wire clean_done = sync2_reg[4];
   wire qchg_start = sync2_reg[5];

   // Address straps are board pins, so they cross in through two flops too
   reg [1:0] pins1_reg;
   reg [1:0] pins2_reg;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pins1_reg <= 2'h0;
         pins2_reg <= 2'h0;
      end else begin
         pins1_reg <= addr_pins_i;
         pins2_reg <= pins1_reg;
      end
   end

   // Registers
   reg brownout_flag_reg;
   reg sleep_exit_reg;
   reg [7:0] bus_cfg_reg;
   reg [7:0] chg_cfg_reg;
   reg [7:0] depop_reg;
   reg [2:0] irq_sts_reg;
   reg [2:0] irq_mask_reg;
   reg brownout_d_reg;
   reg io_present_d_reg;
   reg qchg_start_d_reg;

   // APB decode; zero-wait slave, access phase completes at once
   wire acc = psel_i & penable_i;
   wire wr = acc & pwrite_i & pstrb_i[0];
   wire [9:0] idx = paddr_i[11:2];
   wire mapped = (idx == {2'b00, `IDX_SUPPLY_STATUS}) | (idx == {2'b00, `IDX_BUS_ADDR_CFG}) |
                 (idx == {2'b00, `IDX_CHARGE_SHUTDOWN_BEHAVIOUR_SELECT}) | (idx == {2'b00, `IDX_HP_DEPOP_CFG}) |
                 (idx == {2'b00, `IDX_IRQ_STATUS}) | (idx == {2'b00, `IDX_IRQ_MASK}) |
                 (idx == {2'b00, `IDX_OUT_STATUS});
   wire wr_ok = wr & mapped & (paddr_i[1:0] == 2'b00);

   // Events: analog flag high, I/O flag high (each only with its mode setting 1), brownout shutdown
   wire brownout_rise = brownout & ~brownout_d_reg;
   wire [2:0] events = {brownout_rise, io_high & ~io_supply_mode_o & io_supply_mode_setting_i,
                        analog_high & ~analog_supply_mode_o & analog_supply_mode_setting_i};

   // Register writes; hardware set wins over write-one-to-clear
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         brownout_flag_reg <= 1'b0;
         sleep_exit_reg <= 1'b0;
         bus_cfg_reg <= `RST_BUS_ADDR_CFG;
         chg_cfg_reg <= `RST_CHARGE_SHUTDOWN_BEHAVIOUR_SELECT;
         depop_reg <= `RST_HP_DEPOP_CFG;
         irq_sts_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         brownout_d_reg <= 1'b0;
      end else begin
         brownout_d_reg <= brownout;
         if (brownout_rise)
            brownout_flag_reg <= 1'b1;
         if (wr_ok && idx == {2'b00, `IDX_SUPPLY_STATUS}) begin
            sleep_exit_reg <= pwdata_i[`BIT_SLEEP_EXIT];
         end
         if (wr_ok && idx == {2'b00, `IDX_BUS_ADDR_CFG})
            bus_cfg_reg <= pwdata_i[7:0] & `WRMASK_BUS_ADDR_CFG;
         if (wr_ok && idx == {2'b00, `IDX_CHARGE_SHUTDOWN_BEHAVIOUR_SELECT})
            chg_cfg_reg <= pwdata_i[7:0];
         if (wr_ok && idx == {2'b00, `IDX_HP_DEPOP_CFG})
            depop_reg <= pwdata_i[7:0];
         if (wr_ok && idx == {2'b00, `IDX_IRQ_MASK})
            irq_mask_reg <= pwdata_i[2:0];
         if (wr_ok && idx == {2'b00, `IDX_IRQ_STATUS})
            irq_sts_reg <= (irq_sts_reg & ~pwdata_i[2:0]) | events;
         else
            irq_sts_reg <= irq_sts_reg | events;
      end
   end

   // Read mux, registered in the setup phase for the access phase
   reg [7:0] rd;
   always @* begin
      rd = 8'h00;
      case (idx[7:0])
         `IDX_SUPPLY_STATUS: begin
            rd[`BIT_ANALOG_FLAG] = analog_high;
            rd[`BIT_IO_FLAG] = io_high;
            rd[`BIT_BROWNOUT_FLAG] = brownout_flag_reg;
            rd[`BIT_SLEEP_EXIT] = sleep_exit_reg;
         end
         `IDX_BUS_ADDR_CFG: rd = bus_cfg_reg;
         `IDX_CHARGE_SHUTDOWN_BEHAVIOUR_SELECT: rd = chg_cfg_reg;
         `IDX_HP_DEPOP_CFG: rd = depop_reg;
         `IDX_IRQ_STATUS: rd = {5'h00, irq_sts_reg};
         `IDX_IRQ_MASK: rd = {5'h00, irq_mask_reg};
         `IDX_OUT_STATUS: rd = {5'h00, digital_core_regulator_on_o, quick_charge_active_o, sleep_exit_o};
         default: rd = 8'h00;
      endcase
   end

   // APB answer: ready every access phase, error on unmapped or misaligned address
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & (~mapped | (paddr_i[1:0] != 2'b00));
         // Refused reads return zero; the read mux alone would leak aliased or misaligned words
         if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= (mapped && paddr_i[1:0] == 2'b00) ? {24'h00_0000, rd} : 32'h0000_0000;
      end
   end

   // Quick-charge duration select
   reg [CNT_W-1:0] qchg_len;
   always @* begin
      case (chg_cfg_reg[7:6])
         2'h0: qchg_len = QCHG_T0_CYC[CNT_W-1:0];
         2'h1: qchg_len = QCHG_T1_CYC[CNT_W-1:0];
         2'h2: qchg_len = QCHG_T2_CYC[CNT_W-1:0];
         default: qchg_len = QCHG_T3_CYC[CNT_W-1:0];
      endcase
   end

   // Keep-alive duration select
   reg [CNT_W-1:0] ka_len;
   always @* begin
      case (chg_cfg_reg[3:2])
         2'h0: ka_len = KA_T0_CYC[CNT_W-1:0];
         2'h1: ka_len = KA_T1_CYC[CNT_W-1:0];
         2'h2: ka_len = KA_T2_CYC[CNT_W-1:0];
         default: ka_len = KA_T3_CYC[CNT_W-1:0];
      endcase
   end

   // Quick-charge timer, started by a rising request
   reg [CNT_W-1:0] qchg_cnt_reg;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         qchg_cnt_reg <= {CNT_W{1'b0}};
         qchg_start_d_reg <= 1'b0;
         quick_charge_active_o <= 1'b0;
      end else begin
         qchg_start_d_reg <= qchg_start;
         if (qchg_start && !qchg_start_d_reg) begin
            qchg_cnt_reg <= qchg_len;
            quick_charge_active_o <= 1'b1;
         end else if (qchg_cnt_reg > 1) begin
            qchg_cnt_reg <= qchg_cnt_reg - 1'b1;
         end else begin
            qchg_cnt_reg <= {CNT_W{1'b0}};
            quick_charge_active_o <= 1'b0;
         end
      end
   end

   // Core regulator shutdown sequencer
   localparam S_ON = 2'd0;
   localparam S_KEEP = 2'd1;
   localparam S_OFF = 2'd2;
   reg [1:0] state_reg;
   reg [CNT_W-1:0] ka_cnt_reg;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= S_ON;
         ka_cnt_reg <= {CNT_W{1'b0}};
         io_present_d_reg <= 1'b0;
         digital_core_regulator_on_o <= 1'b1;
      end else begin
         io_present_d_reg <= io_present;
         case (state_reg)
            S_ON: begin
               digital_core_regulator_on_o <= 1'b1;
               if (io_present_d_reg && !io_present) begin
                  case (chg_cfg_reg[5:4])
                     `SHDN_IMMEDIATE: begin
                        state_reg <= S_OFF;
                        digital_core_regulator_on_o <= 1'b0;
                     end
                     `SHDN_TIMEOUT: begin
                        state_reg <= S_KEEP;
                        ka_cnt_reg <= ka_len;
                     end
                     // wait for clean shutdown; reserved code treated alike
                     default: state_reg <= S_KEEP;
                  endcase
               end
            end
            S_KEEP: begin
               if (io_present) begin
                  state_reg <= S_ON;
               end else if (chg_cfg_reg[5:4] == `SHDN_TIMEOUT) begin
                  if (ka_cnt_reg <= 1) begin
                     state_reg <= S_OFF;
                     digital_core_regulator_on_o <= 1'b0;
                  end else begin
                     ka_cnt_reg <= ka_cnt_reg - 1'b1;
                  end
               end else if (clean_done || chg_cfg_reg[5:4] == `SHDN_IMMEDIATE) begin
                  state_reg <= S_OFF;
                  digital_core_regulator_on_o <= 1'b0;
               end
            end
            S_OFF: begin
               digital_core_regulator_on_o <= 1'b0;
               if (io_present) begin
                  state_reg <= S_ON;
                  digital_core_regulator_on_o <= 1'b1;
               end
            end
            default: state_reg <= S_ON;
         endcase
      end
   end

   // Effective modes, address, de-pop selects and interrupt
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         analog_supply_mode_o <= 1'b0;
         io_supply_mode_o <= 1'b0;
         bus_target_addr_o <= 7'h00;
         sleep_exit_o <= 1'b0;
         headphone_series_resistor_select_o <= 4'h5;
         headphone_cap_charge_time_o <= 4'h5;
         irq_o <= 1'b0;
      end else begin
         analog_supply_mode_o <= analog_supply_mode_setting_i & ~analog_high;
         io_supply_mode_o <= io_supply_mode_setting_i & ~io_high;
         if (bus_cfg_reg[`BIT_BROADCAST_EN])
            bus_target_addr_o <= {BROADCAST_BASE[6:2], 2'h0};
         else
            bus_target_addr_o <= {BROADCAST_BASE[6:2], pins2_reg};
         sleep_exit_o <= brownout_flag_reg & sleep_exit_reg;
         headphone_series_resistor_select_o <= depop_reg[7:4];
         headphone_cap_charge_time_o <= depop_reg[3:0];
         irq_o <= |(irq_sts_reg & irq_mask_reg);
      end
   end

endmodule // supply_shutdown_depop_regs

// ==== bench/supply_shutdown_depop_regs_props.sv ====
/* Port checker for the supply, shutdown and de-pop register block.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/100ps
module supply_shutdown_depop_regs_props #(parameter [6:0] BROADCAST_BASE = 7'h50) (
   // Clock, reset and APB
   input wire clk_i,
   input wire rstn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   // Supply side
   input wire analog_supply_high_i,
   input wire io_supply_high_i,
   input wire io_supply_present_i,
   input wire analog_supply_mode_setting_i,
   input wire io_supply_mode_setting_i,
   input wire analog_supply_mode_o,
   input wire io_supply_mode_o,
   input wire [6:0] bus_target_addr_o,
   input wire digital_core_regulator_on_o
);
   // One domain; reset cancels every check
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("pready held");
   a_ready_no_wait: assert property (psel_i && !penable_i |=> pready_o) else $error("no prompt pready");
   a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
   a_err_read_zero: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
      else $error("error read not zero");
   a_analog_mode_forced: assert property (analog_supply_high_i [*6] |-> !analog_supply_mode_o)
      else $error("analog mode not forced");
   a_analog_mode_kept: assert property ((!analog_supply_high_i && analog_supply_mode_setting_i) [*6] |->
      analog_supply_mode_o) else $error("analog mode lost");
   a_io_mode_forced: assert property (io_supply_high_i [*6] |-> !io_supply_mode_o)
      else $error("io mode not forced");
   a_io_mode_kept: assert property ((!io_supply_high_i && io_supply_mode_setting_i) [*6] |->
      io_supply_mode_o) else $error("io mode lost");
   a_regulator_back_on: assert property (io_supply_present_i [*6] |-> digital_core_regulator_on_o)
      else $error("regulator off with supply");
   a_broadcast_base: assert property ($past(rstn_i) && $past(rstn_i, 2) && $past(rstn_i, 3) |->
      bus_target_addr_o[6:2] == BROADCAST_BASE[6:2]) else $error("target address base wrong");
endmodule // supply_shutdown_depop_regs_props

bind supply_shutdown_depop_regs supply_shutdown_depop_regs_props #(.BROADCAST_BASE(BROADCAST_BASE)) i_props (
   .clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o,
   .analog_supply_high_i, .io_supply_high_i, .io_supply_present_i, .analog_supply_mode_setting_i,
   .io_supply_mode_setting_i, .analog_supply_mode_o, .io_supply_mode_o, .bus_target_addr_o,
   .digital_core_regulator_on_o
);

// ==== bench/testbench.sv ====
/* Self-checking bench for the supply, shutdown and de-pop register block.
   Drives APB and the analog indications itself; timing counts are shortened. */
`timescale 1ns/100ps
`include "supply_shutdown_depop_regs.vh"
module testbench;
   localparam int QC [4] = '{20, 30, 40, 50};
   localparam int KA [4] = '{60, 50, 40, 30};
   localparam bit [7:0] SUP = `IDX_SUPPLY_STATUS, BUS = `IDX_BUS_ADDR_CFG, CHG = `IDX_CHARGE_SHUTDOWN_BEHAVIOUR_SELECT;
   localparam bit [7:0] DEP = `IDX_HP_DEPOP_CFG, IST = `IDX_IRQ_STATUS, IMK = `IDX_IRQ_MASK;
   logic clk_i = 1'h0, rstn_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, err;
   logic [11:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, rd;
   logic [3:0] pstrb_i = '0;
   logic analog_supply_high_i = 1'h0, io_supply_high_i = 1'h0, io_supply_present_i = 1'h1;
   logic brownout_event_i = 1'h0, clean_shutdown_done_i = 1'h0, quick_charge_start_i = 1'h0;
   logic [1:0] addr_pins_i = 2'h3;
   logic analog_supply_mode_setting_i = 1'h1, io_supply_mode_setting_i = 1'h1;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, analog_supply_mode_o, io_supply_mode_o, quick_charge_active_o;
   wire digital_core_regulator_on_o, sleep_exit_o, irq_o;
   wire [6:0] bus_target_addr_o;
   wire [3:0] headphone_series_resistor_select_o, headphone_cap_charge_time_o;
   int mismatches = 0, n_compared = 0;

   // Short counts keep the run brief
   supply_shutdown_depop_regs #(.QCHG_T0_CYC(QC[0]), .QCHG_T1_CYC(QC[1]), .QCHG_T2_CYC(QC[2]),
      .QCHG_T3_CYC(QC[3]), .KA_T0_CYC(KA[0]), .KA_T1_CYC(KA[1]), .KA_T2_CYC(KA[2]), .KA_T3_CYC(KA[3])
   ) i_supply_shutdown_depop_regs (
      .clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
      .pslverr_o, .analog_supply_high_i, .io_supply_high_i, .io_supply_present_i, .brownout_event_i,
      .clean_shutdown_done_i, .quick_charge_start_i, .addr_pins_i, .analog_supply_mode_setting_i,
      .io_supply_mode_setting_i, .analog_supply_mode_o, .io_supply_mode_o, .bus_target_addr_o,
      .quick_charge_active_o, .digital_core_regulator_on_o, .sleep_exit_o,
      .headphone_series_resistor_select_o, .headphone_cap_charge_time_o, .irq_o
   );

   // Clock, 5 ns period
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // One APB transfer; pready is awaited under a bound, data taken at that edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s = 4'h1);
      int k;
      @(posedge clk_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= {2'h0, idx, 2'h0};
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge clk_i);
      penable_i <= 1'h1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'h1 && k < 20);
      if (k >= 20) begin
         mismatches++;
         close_out();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
      apb(1'h0, idx, 32'h0000_0000);
      chk(nm, rd, exp);
   endtask

   task automatic t_reset;
      rdc("supply_status", SUP, 32'h0000_0000);
      rdc("bus_cfg", BUS, 32'h0000_0000);
      rdc("chg_cfg", CHG, 32'h0000_0015);
      rdc("depop_cfg", DEP, 32'h0000_0055);
      chk("series_sel", headphone_series_resistor_select_o, 4'h5);
      chk("reg_on", digital_core_regulator_on_o, 1'h1);
      $display("t_reset done");
   endtask

   task automatic t_bus;
      logic [7:0] d;
      chk("addr_off", bus_target_addr_o, 7'h53);
      apb(1'h1, BUS, 32'h0000_0002);
      cyc(3);
      chk("addr_on", bus_target_addr_o, 7'h50);
      // Lane 0 not strobed, so the write must not land
      apb(1'h1, BUS, 32'h0000_0000, 4'h0);
      rdc("bus_strb", BUS, 32'h0000_0002);
      apb(1'h1, BUS, 32'h0000_0000);
      cyc(3);
      chk("addr_back", bus_target_addr_o, 7'h53);
      for (int i = 0; i < 10; i++) begin
         d = {(i > 8) ? 4'h8 : 4'(i), 4'(i)};
         apb(1'h1, DEP, {24'h00_0000, d});
         rdc("depop_rb", DEP, {24'h00_0000, d});
         chk("series", headphone_series_resistor_select_o, d[7:4]);
         chk("chg_time", headphone_cap_charge_time_o, d[3:0]);
      end
      apb(1'h0, 8'h07, 32'h0000_0000);
      chk("slverr", err, 1'h1);
      chk("unmapped_rd", rd, 32'h0000_0000);
      $display("t_bus done");
   endtask

   task automatic t_supply;
      apb(1'h1, IMK, 32'h0000_0007);
      analog_supply_high_i <= 1'h1;
      cyc(6);
      chk("amode", analog_supply_mode_o, 1'h0);
      chk("iomode", io_supply_mode_o, 1'h1);
      rdc("sts_a", SUP, 32'h0000_0080);
      chk("irq_a", irq_o, 1'h1);
      analog_supply_high_i <= 1'h0;
      cyc(6);
      chk("amode_back", analog_supply_mode_o, 1'h1);
      rdc("irq_sts", IST, 32'h0000_0001);
      apb(1'h1, IST, 32'h0000_0001);
      cyc(2);
      chk("irq_clr", irq_o, 1'h0);
      io_supply_high_i <= 1'h1;
      cyc(6);
      chk("iomode_f", io_supply_mode_o, 1'h0);
      rdc("sts_io", SUP, 32'h0000_0040);
      apb(1'h1, IMK, 32'h0000_0000);
      cyc(2);
      chk("irq_masked", irq_o, 1'h0);
      apb(1'h1, IMK, 32'h0000_0007);
      cyc(2);
      chk("irq_unmask", irq_o, 1'h1);
      io_supply_high_i <= 1'h0;
      apb(1'h1, IST, 32'h0000_0002);
      cyc(2);
      chk("irq_clr2", irq_o, 1'h0);
      $display("t_supply done");
   endtask

   task automatic t_brown;
      brownout_event_i <= 1'h1;
      cyc(4);
      brownout_event_i <= 1'h0;
      cyc(4);
      rdc("sts_bo", SUP, 32'h0000_0002);
      chk("stay_sleep", sleep_exit_o, 1'h0);
      rdc("irq_bo", IST, 32'h0000_0004);
      // Read-only bits written high, reserved bits kept at reset value
      apb(1'h1, SUP, 32'h0000_00C3);
      rdc("sts_ro", SUP, 32'h0000_0003);
      chk("exit_sleep", sleep_exit_o, 1'h1);
      apb(1'h1, IST, 32'h0000_0004);
      cyc(2);
      chk("irq_bo_clr", irq_o, 1'h0);
      rdc("out_sts", `IDX_OUT_STATUS, 32'h0000_0005);
      $display("t_brown done");
   endtask

   task automatic t_qchg;
      int n;
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, CHG, {24'h00_0000, 2'(i), 6'h15});
         quick_charge_start_i <= 1'h1;
         n = 0;
         while (quick_charge_active_o !== 1'h1 && n < 10) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 10) begin
            mismatches++;
            close_out();
         end
         n = 0;
         while (quick_charge_active_o === 1'h1 && n < 300) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 300) begin
            mismatches++;
            close_out();
         end
         chk("qchg_len", n >= QC[i] - 2 && n <= QC[i] + 2, 1'h1);
         quick_charge_start_i <= 1'h0;
      end
      $display("t_qchg done");
   endtask

   // Cycles from supply removal until the regulator drops, bounded
   task automatic off_wait(output int n);
      n = 0;
      while (digital_core_regulator_on_o === 1'h1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 400) begin
         mismatches++;
         close_out();
      end
   endtask

   task automatic back_on;
      io_supply_present_i <= 1'h1;
      cyc(8);
      chk("reg_back", digital_core_regulator_on_o, 1'h1);
   endtask

   task automatic t_reg;
      int n;
      apb(1'h1, CHG, 32'h0000_0001);
      io_supply_present_i <= 1'h0;
      off_wait(n);
      chk("off_now", n <= 6, 1'h1);
      back_on();
      for (int k = 0; k < 4; k++) begin
         apb(1'h1, CHG, {24'h00_0000, 4'h1, 2'(k), 2'h1});
         io_supply_present_i <= 1'h0;
         off_wait(n);
         chk("ka_len", n >= KA[k] && n <= KA[k] + 6, 1'h1);
         back_on();
      end
      // Code 2 only; code 3 stays unused
      apb(1'h1, CHG, 32'h0000_0021);
      io_supply_present_i <= 1'h0;
      cyc(100);
      chk("clean_hold", digital_core_regulator_on_o, 1'h1);
      clean_shutdown_done_i <= 1'h1;
      off_wait(n);
      chk("clean_off", n <= 6, 1'h1);
      clean_shutdown_done_i <= 1'h0;
      back_on();
      $display("t_reg done");
   endtask

   // Reset for 20 cycles, then the scenarios in turn
   initial begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'h1;
      t_reset();
      t_bus();
      t_supply();
      t_brown();
      t_qchg();
      t_reg();
      close_out();
   end
endmodule // testbench
